// ### core/pbs_pkg.sv
// pbs_pkg: shared constants and types of the pipelined burst sram access block.
// assumes one clock domain; the far side samples and drives on the rising edge.
`default_nettype none

package pbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // structure
  localparam int PBS_BURST_W = 2;
  localparam int PBS_LANES = 4;
  localparam int PBS_SYNC_N = 2;
  localparam int PBS_BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic PBS_CTRL_N_RST = 1'h1;
  localparam logic PBS_CTRL_RST = 1'h0;
  localparam logic PBS_MODE_RST = 1'h1;
  localparam logic [PBS_BURST_W-1:0] PBS_CNT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // selection state
  typedef enum logic {
    PBS_ST_DESEL,
    PBS_ST_ACTIVE
  } pbs_state_type;

endpackage : pbs_pkg

`default_nettype wire

// ### core/pbs_burst_ctr.sv
// pbs_burst_ctr: two-bit wraparound burst counter with interleaved or linear order.
// assumes load and step are already qualified by the caller's clock enable.
`timescale 1ns/1ps
`default_nettype none

module pbs_burst_ctr
  import pbs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [PBS_BURST_W-1:0] i_start,
  input wire logic i_step,
  input wire logic i_interleave,
  output logic [PBS_BURST_W-1:0] o_cur,
  output logic [PBS_BURST_W-1:0] o_nxt
);

  logic [PBS_BURST_W-1:0] start_q;
  logic [PBS_BURST_W-1:0] cnt_q;

  function automatic logic [PBS_BURST_W-1:0] burst_off(
    input logic [PBS_BURST_W-1:0] start,
    input logic [PBS_BURST_W-1:0] cnt,
    input logic inter
  );
    burst_off = inter ? (start ^ cnt) : PBS_BURST_W'(start + cnt);
  endfunction : burst_off

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= PBS_CNT_RST;
      cnt_q <= PBS_CNT_RST;
    end else if (i_load) begin
      start_q <= i_start;
      cnt_q <= PBS_CNT_RST;
    end else if (i_step) begin
      cnt_q <= PBS_BURST_W'(cnt_q + 1'h1);
    end
  end

  assign o_cur = burst_off(start_q, cnt_q, i_interleave);
  assign o_nxt = burst_off(start_q, PBS_BURST_W'(cnt_q + 1'h1), i_interleave);

endmodule : pbs_burst_ctr

`default_nettype wire

// ### core/pbs_skid_buf.sv
// pbs_skid_buf: small valid/ready buffer; ready and valid come straight from flops.
// assumes i_en freezes all state when low.
`timescale 1ns/1ps
`default_nettype none

module pbs_skid_buf
  import pbs_pkg::*;
#(
  parameter int WIDTH = 37,
  parameter int DEPTH = PBS_BUF_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = i_en & i_valid & o_ready;
  assign pop = i_en & i_ready & o_valid;
  assign cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
  assign o_data = mem[rd_q];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
  end

  // full and empty kept as flops so ready never depends on the consumer
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      o_ready <= 1'h1;
      o_valid <= 1'h0;
    end else if (i_en) begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'h1);
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'h1);
      end
      cnt_q <= cnt_d;
      o_ready <= (cnt_d != CW'(DEPTH));
      o_valid <= (cnt_d != '0);
    end
  end

endmodule : pbs_skid_buf

`default_nettype wire

// ### core/pbs_sram_core.sv
// pbs_sram_core: pipelined burst sram access logic with its own storage array.
// assumes the far side drives all synchronous inputs on i_ref_clk; output enable
// and burst order arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module pbs_sram_core
  import pbs_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 36
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic i_chip_select_primary_n,
  input wire logic i_chip_select_secondary,
  input wire logic i_chip_select_tertiary_n,
  input wire logic i_processor_address_strobe_n,
  input wire logic i_controller_address_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [PBS_LANES-1:0] i_byte_lane_write_select_n,
  input wire logic i_output_enable_n,
  input wire logic i_burst_mode,
  output logic o_access_ready,
  output logic o_rd_valid,
  input wire logic i_rd_ready
);

  localparam int LANE_W = DATA_W / PBS_LANES;
  localparam int BASE_W = ADDR_W - PBS_BURST_W;
  localparam int DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [PBS_SYNC_N-1:0] oe_n_sync_q;
  logic [PBS_SYNC_N-1:0] mode_sync_q;
  logic oe_n;
  logic interleave;

  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dq_in_q;
  logic cs1_n_q;
  logic cs2_q;
  logic cs3_n_q;
  logic pstb_n_q;
  logic cstb_n_q;
  logic step_n_q;
  logic wall_n_q;
  logic lane_en_n_q;
  logic [PBS_LANES-1:0] lane_sel_n_q;

  pbs_state_type state_q;
  logic [BASE_W-1:0] base_q;
  logic desel_q;

  logic cs_all;
  logic pstb_go;
  logic cstb_go;
  logic start;
  logic desel;
  logic cont;
  logic use_next;
  logic [PBS_LANES-1:0] wr_mask;
  logic is_write;
  logic is_read;
  logic wr_seen;
  logic first_rd;
  logic stall;
  logic run;
  logic [PBS_BURST_W-1:0] cur_off;
  logic [PBS_BURST_W-1:0] nxt_off;
  logic [ADDR_W-1:0] acc_addr;

  logic [DATA_W-1:0] mem [DEPTH];

  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W:0] buf_out;
  logic pop;

  logic out_valid_q;
  logic out_first_q;
  logic out_valid_d;
  logic out_first_d;

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by data and output-enable paths

  function automatic logic [PBS_LANES-1:0] lane_mask(
    input logic wall_n,
    input logic lane_en_n,
    input logic [PBS_LANES-1:0] lane_sel_n
  );
    if (!wall_n) begin
      lane_mask = '1;
    end else if (!lane_en_n) begin
      lane_mask = ~lane_sel_n;
    end else begin
      lane_mask = '0;
    end
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the asynchronous pins

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_n_sync_q <= '1;
      mode_sync_q <= {PBS_SYNC_N{PBS_MODE_RST}};
    end else if (i_clk_en) begin
      oe_n_sync_q <= {oe_n_sync_q[0], i_output_enable_n};
      mode_sync_q <= {mode_sync_q[0], i_burst_mode};
    end
  end

  // output enable costs two cycles of lag; the price of a safe crossing
  assign oe_n = oe_n_sync_q[PBS_SYNC_N-1];
  assign interleave = mode_sync_q[PBS_SYNC_N-1];

  assign run = i_clk_en & ~stall;

  ////////////////////////////////////////////////////////////////////////////
  // input registers

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= '0;
      dq_in_q <= '0;
      cs1_n_q <= PBS_CTRL_N_RST;
      cs2_q <= PBS_CTRL_RST;
      cs3_n_q <= PBS_CTRL_N_RST;
      pstb_n_q <= PBS_CTRL_N_RST;
      cstb_n_q <= PBS_CTRL_N_RST;
      step_n_q <= PBS_CTRL_N_RST;
      wall_n_q <= PBS_CTRL_N_RST;
      lane_en_n_q <= PBS_CTRL_N_RST;
      lane_sel_n_q <= '1;
    end else if (run) begin
      addr_q <= i_addr;
      dq_in_q <= i_dq;
      cs1_n_q <= i_chip_select_primary_n;
      cs2_q <= i_chip_select_secondary;
      cs3_n_q <= i_chip_select_tertiary_n;
      pstb_n_q <= i_processor_address_strobe_n;
      cstb_n_q <= i_controller_address_strobe_n;
      step_n_q <= i_burst_advance_n;
      wall_n_q <= i_global_write_n;
      lane_en_n_q <= i_byte_write_enable_n;
      lane_sel_n_q <= i_byte_lane_write_select_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode

  assign cs_all = ~cs1_n_q & cs2_q & ~cs3_n_q;
  assign pstb_go = ~pstb_n_q & ~cs1_n_q;
  assign cstb_go = ~cstb_n_q & ~pstb_go;
  assign start = (pstb_go | cstb_go) & cs_all;
  assign desel = (pstb_go | cstb_go) & ~cs_all;
  assign cont = ~pstb_go & ~cstb_go & (state_q == PBS_ST_ACTIVE);

  assign wr_mask = pstb_go ? '0 : lane_mask(wall_n_q, lane_en_n_q, lane_sel_n_q);
  assign is_write = (start | cont) & (|wr_mask);
  assign is_read = (start | cont) & ~(|wr_mask);

  assign use_next = cont & ~step_n_q;

  assign first_rd = start & (state_q == PBS_ST_DESEL);
  // any registered write control counts, so a write never meets a driven bus
  assign wr_seen = is_write | (|lane_mask(wall_n_q, lane_en_n_q, lane_sel_n_q));

  // a read that finds the buffer full holds the whole input stage
  assign stall = is_read & ~buf_in_ready;

  always_comb begin
    if (start) begin
      acc_addr = addr_q;
    end else begin
      acc_addr = {base_q, use_next ? nxt_off : cur_off};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst counter

  pbs_burst_ctr u_ctr (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_load(run & start),
    .i_start(addr_q[PBS_BURST_W-1:0]),
    .i_step(run & use_next),
    .i_interleave(interleave),
    .o_cur(cur_off),
    .o_nxt(nxt_off)
  );

  ////////////////////////////////////////////////////////////////////////////
  // selection state and base address

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= PBS_ST_DESEL;
      base_q <= '0;
      desel_q <= 1'h0;
    end else if (run) begin
      desel_q <= desel;
      if (start) begin
        state_q <= PBS_ST_ACTIVE;
        base_q <= addr_q[ADDR_W-1:PBS_BURST_W];
      end else if (desel) begin
        state_q <= PBS_ST_DESEL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage array; no reset, contents are undefined until written

  always_ff @(posedge i_ref_clk) begin
    if (run && is_write) begin
      for (int g = 0; g < PBS_LANES; g++) begin
        if (wr_mask[g]) begin
          mem[acc_addr][g*LANE_W +: LANE_W] <= dq_in_q[g*LANE_W +: LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read buffer; a stalled receiver fills it and then holds the inputs

  pbs_skid_buf #(
    .WIDTH(DATA_W + 1),
    .DEPTH(PBS_BUF_DEPTH)
  ) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_en(i_clk_en),
    .i_valid(is_read),
    .i_data({first_rd, mem[acc_addr]}),
    .o_ready(buf_in_ready),
    .o_valid(buf_out_valid),
    .o_data(buf_out),
    .i_ready(pop)
  );

  assign o_access_ready = buf_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // output register and drive enable

  assign pop = buf_out_valid & (~out_valid_q | i_rd_ready) & ~desel_q;

  always_comb begin
    out_valid_d = out_valid_q;
    out_first_d = out_first_q;
    if (pop) begin
      out_valid_d = 1'h1;
      out_first_d = buf_out[DATA_W];
    end else if (desel_q || (out_valid_q && i_rd_ready)) begin
      out_valid_d = 1'h0;
      out_first_d = 1'h0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dq <= '0;
      out_valid_q <= 1'h0;
      out_first_q <= 1'h0;
    end else if (i_clk_en) begin
      if (pop) begin
        o_dq <= buf_out[DATA_W-1:0];
      end
      out_valid_q <= out_valid_d;
      out_first_q <= out_first_d;
    end
  end

  assign o_rd_valid = out_valid_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dq_oe <= 1'h0;
    end else if (i_clk_en) begin
      // drive drops on the decoded deselect, one rise after it is taken;
      // the held word is cleared a rise later, so a consumer that waits loses it
      o_dq_oe <= out_valid_d & ~out_first_d & ~oe_n & ~wr_seen & ~desel & ~desel_q;
    end
  end

endmodule : pbs_sram_core

`default_nettype wire

// ### sim/pbs_sram_monitor.sv
// pbs_sram_monitor: port-level checks of the burst sram block.
// assumes one clock; bound onto every pbs_sram_core instance.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_monitor
  import pbs_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 36
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe,
  input wire logic i_chip_select_primary_n,
  input wire logic i_chip_select_secondary,
  input wire logic i_chip_select_tertiary_n,
  input wire logic i_processor_address_strobe_n,
  input wire logic i_controller_address_strobe_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [PBS_LANES-1:0] i_byte_lane_write_select_n,
  input wire logic i_output_enable_n,
  input wire logic o_access_ready,
  input wire logic o_rd_valid,
  input wire logic i_rd_ready
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic sel = !i_chip_select_primary_n && i_chip_select_secondary && !i_chip_select_tertiary_n;
  wire logic pstart = !i_processor_address_strobe_n && sel && o_access_ready && i_clk_en;
  wire logic desel = !i_controller_address_strobe_n && i_chip_select_primary_n && o_access_ready;
  wire logic wctl = !i_global_write_n || (!i_byte_write_enable_n && !(&i_byte_lane_write_select_n));
  ////////////////////////////////////////////////////////////////////////////
  // drive only words
  oe_has_word_a: assert property (o_dq_oe |-> o_rd_valid) else $error("driving without a word");
  oe_gate_a: assert property (i_output_enable_n [*4] |-> !o_dq_oe) else $error("drive while disabled");
  wr_tristate_a: assert property ((wctl && i_processor_address_strobe_n && o_access_ready) |-> ##2 !o_dq_oe)
    else $error("drive during write");
  desel_off_a: assert property (desel |-> ##2 !o_dq_oe ##1 (!o_dq_oe && !o_rd_valid)) else $error("deselect late");
  rd_latency_a: assert property ((pstart && i_rd_ready) |-> ##3 o_rd_valid) else $error("read word late");
  first_mask_a: assert property (desel ##1 pstart |-> ##3 !o_dq_oe) else $error("first word driven");
  hold_word_a: assert property ((o_rd_valid && !i_rd_ready) |=> (!o_rd_valid || $stable(o_dq)))
    else $error("word changed while held");
  proc_wins_a: assert property ((pstart && !i_controller_address_strobe_n && !i_global_write_n && i_rd_ready)
    |-> ##3 o_rd_valid) else $error("strobe clash not a read");
  cover property (pstart ##3 o_dq_oe);
  cover property (desel ##2 !o_rd_valid);
  cover property (!o_access_ready);
endmodule : pbs_sram_monitor
bind pbs_sram_core pbs_sram_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_pbs_sram_monitor (.*);
`default_nettype wire

// ### sim/pbs_host_model.sv
// pbs_host_model: processor or cache controller facing the sram block.
// assumes one cyc call per clock; everything changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model (
  input wire logic i_ref_clk,
  output logic [7:0] o_addr,
  output logic [35:0] o_dq,
  output logic [9:0] o_ctl,
  output logic o_output_enable_n,
  output logic o_burst_mode
);
  logic want_oe = 1'h0;
  initial begin
    o_addr = 8'h00;
    o_dq = 36'h0;
    o_ctl = 10'h2ff;
    o_output_enable_n = 1'h1;
    o_burst_mode = 1'h1;
  end
  task automatic cyc(input logic [9:0] k, input logic [7:0] a, input logic [35:0] d);
    @(negedge i_ref_clk);
    o_ctl = k;
    o_addr = a;
    // released lines flip, so a stale copy never looks valid
    o_dq = (k[6] && k[5]) ? ~o_dq : d;
    o_output_enable_n = !want_oe || !k[6] || !k[5];
  endtask : cyc
  task automatic strap(input logic m);
    o_burst_mode = m;
  endtask : strap
endmodule : pbs_host_model
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: self-checking bench of the burst sram block.
// assumes the host model drives the bus; ctl bits 9..0 are strobes, advance, writes, select, lanes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [9:0] IDLE = 10'h3ef;
  localparam logic [9:0] DESEL = 10'h2ff;
  localparam logic [9:0] RD = 10'h1ef;
  localparam logic [9:0] STEP = 10'h36f;
  localparam logic [53:0] ROWS [7] = '{{10'h2af, 8'h40, 36'h123456789}, {10'h2af, 8'h41, 36'hf0f0f0f0f},
    {10'h2af, 8'h42, 36'h0a5a5a5a5}, {10'h2af, 8'h43, 36'h987654321}, {10'h2ca, 8'h41, 36'h111111111},
    {10'h2c0, 8'h42, 36'h222222222}, {10'h0af, 8'h40, 36'hfffffffff}};
  logic i_ref_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic i_rd_ready = 1'h1;
  logic [7:0] a;
  logic [7:0] aa;
  logic [35:0] d;
  logic [35:0] dd;
  logic [9:0] k;
  logic [9:0] kk;
  logic oe_n;
  logic mode;
  logic [35:0] o_dq;
  logic o_dq_oe;
  logic o_access_ready;
  logic o_rd_valid;
  logic [35:0] mem [256];
  int fails = 0;
  int checked = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  pbs_host_model i_pbs_host_model (.i_ref_clk(i_ref_clk), .o_addr(a), .o_dq(d), .o_ctl(k),
    .o_output_enable_n(oe_n), .o_burst_mode(mode));
  pbs_sram_core #(.ADDR_W(8), .DATA_W(36)) i_pbs_sram_core (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_clk_en(1'h1), .i_addr(a), .i_dq(d), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_chip_select_primary_n(k[4]),
    .i_chip_select_secondary(1'h1), .i_chip_select_tertiary_n(1'h0), .i_processor_address_strobe_n(k[9]),
    .i_controller_address_strobe_n(k[8]), .i_burst_advance_n(k[7]), .i_global_write_n(k[6]),
    .i_byte_write_enable_n(k[5]), .i_byte_lane_write_select_n(k[3:0]), .i_output_enable_n(oe_n),
    .i_burst_mode(mode), .o_access_ready(o_access_ready), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] ra);
    i_pbs_host_model.cyc(RD, ra, 36'h0);
    i_pbs_host_model.cyc(DESEL, ra, 36'h0);
    i_pbs_host_model.cyc(IDLE, ra, 36'h0);
    @(negedge i_ref_clk);
    chk({35'h0, o_rd_valid}, 36'h1);
    chk(o_dq, mem[ra]);
  endtask : rdchk
  task automatic rst(input logic m);
    i_arst_n = 1'h0;
    i_pbs_host_model.strap(m);
    repeat (3) @(negedge i_ref_clk);
    chk({33'h0, o_access_ready, o_rd_valid, o_dq_oe}, 36'h4);
    i_arst_n = 1'h1;
  endtask : rst
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst(1'h1);
    foreach (ROWS[i]) begin
      {kk, aa, dd} = ROWS[i];
      i_pbs_host_model.cyc(kk, aa, dd);
      for (int g = 0; g < 4; g++) begin
        if (kk[9] && (!kk[6] || (!kk[5] && !kk[g]))) mem[aa][g*9+:9] = dd[g*9+:9];
      end
      rdchk(aa);
    end
    i_pbs_host_model.cyc(RD, 8'h43, 36'h0);
    i_pbs_host_model.cyc(10'h3af, 8'h00, 36'h333333333);
    mem[8'h43] = 36'h333333333;
    rdchk(8'h43);
    // processor strobe with primary high mid-burst must act as a plain continue
    i_pbs_host_model.cyc(RD, 8'h40, 36'h0);
    i_pbs_host_model.cyc(10'h17f, 8'h00, 36'h0);
    i_pbs_host_model.cyc(DESEL, 8'h0, 36'h0);
    i_pbs_host_model.cyc(IDLE, 8'h0, 36'h0);
    @(negedge i_ref_clk);
    chk(o_dq, mem[8'h41]);
    for (int m = 1; m >= 0; m--) begin
      rst(m[0]);
      i_pbs_host_model.want_oe = 1'h1;
      i_pbs_host_model.cyc(DESEL, 8'h0, 36'h0);
      i_pbs_host_model.cyc(RD, 8'h41, 36'h0);
      i_pbs_host_model.cyc(STEP, 8'h0, 36'h0);
      i_pbs_host_model.cyc(STEP, 8'h0, 36'h0);
      for (int i = 0; i < 4; i++) begin
        i_pbs_host_model.cyc(i == 0 ? STEP : (i == 1 ? DESEL : IDLE), 8'h0, 36'h0);
        chk(o_dq, mem[m ? 8'h40 + 8'(1 ^ i) : 8'h40 + 8'((1 + i) % 4)]);
        chk({35'h0, o_dq_oe}, {35'h0, i == 1 || i == 2});
      end
    end
    // buffer fills while the consumer stalls
    i_rd_ready = 1'h0;
    i_pbs_host_model.cyc(RD, 8'h40, 36'h0);
    i_pbs_host_model.cyc(IDLE, 8'h0, 36'h0);
    repeat (4) @(negedge i_ref_clk);
    chk({35'h0, o_access_ready}, 36'h0);
    chk(o_dq, mem[8'h40]);
    i_rd_ready = 1'h1;
    i_pbs_host_model.cyc(DESEL, 8'h0, 36'h0);
    repeat (6) @(negedge i_ref_clk);
    chk({34'h0, o_rd_valid, o_access_ready}, 36'h1);
    end_of_test();
  end
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
